// ### design/hpi_pkg.sv
// ---------------------------------------------------------------
// shared constants for the host port
// ---------------------------------------------------------------
package hpi_pkg;
   // bus widths and write buffer depth
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int SYNC_W     = 2 + 4 + 2 + ADDR_W + DATA_W;

   // byte-port register select codes
   localparam logic [1:0] SEL_CTRL     = 2'h0;
   localparam logic [1:0] SEL_DATA_INC = 2'h1;
   localparam logic [1:0] SEL_ADDR     = 2'h2;
   localparam logic [1:0] SEL_DATA     = 2'h3;

   // control register bit positions
   localparam int CTRL_DEV_INT_BIT  = 1;
   localparam int CTRL_HOST_INT_BIT = 2;

   // values after reset
   localparam logic [ADDR_W-1:0] ADDR_RST  = 18'h00000;
   localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
   localparam logic [SYNC_W-1:0] SYNC_RST  = 42'h1c000000000; // select and strobes idle high

   // host-side sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WR_DMA,
      ST_RD_DMA
   } hpi_state_t;
endpackage : hpi_pkg

// ### design/hpi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// small valid/ready fifo
// ---------------------------------------------------------------
module hpi_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // fill side
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic [WIDTH-1:0]      o_data
);
   localparam int PW = $clog2(DEPTH);

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("hpi_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // pointer and count update
   always_comb begin
      push  = i_valid && o_ready;
      pop   = o_valid && i_ready;
      wp_d  = push ? wp_q + 1'b1 : wp_q;
      rp_d  = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // storage, no reset needed
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_q] <= i_data;
      end
   end

   // honest full and empty
   assign o_ready = (cnt_q != DEPTH[PW:0]);
   assign o_valid = (cnt_q != '0);
   assign o_data  = mem[rp_q];
endmodule : hpi_fifo
`default_nettype wire

// ### design/hpi_port.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// host port: byte or word host to on-chip memory over dma
// ---------------------------------------------------------------
// Behaviour
// - width select high gives a 16-bit host port, only with external buses idle; no external bus state gates it here
// - width select low gives an 8-bit port between processors
// - byte mode moves each word as two bytes, host marks high or low half
// - byte mode uses exactly address, data and control registers
// - address and data only host-reachable; control reachable by host and processor
// - byte mode offers auto-incrementing and fixed-address data transfers
// - byte mode can interrupt both the host and the processor
// - host transfers reach all on-chip ram over the dma bus; byte-mode address writes load only 16 bits, upper 2 cleared
// - host transfers keep completing during an emulation stop
// - word mode has 16-bit data and 18-bit address reaching all pages
// - word mode supports only separate address and data buses
// - word mode stalls the host through ready until a write is buffered or a dma read completes
// - host access is synchronised; on collision host wins, processor waits while the dma request to its address is held
// - control register unavailable in word mode
// - every word-mode host access launches a dma read or write
// - word mode data over data bus, address over separate address bus
module hpi_port (
   // clock and reset
   input  wire logic                       I_CLK,
   input  wire logic                       I_RESET_N,
   // host pins
   input  wire logic                       I_HOST_WIDTH_SELECT,
   input  wire logic                       I_HOST_CHIP_SELECT_N,
   input  wire logic                       I_HOST_DATA_STROBE_A_N,
   input  wire logic                       I_HOST_DATA_STROBE_B_N,
   input  wire logic                       I_HOST_READ_NOT_WRITE,
   input  wire logic                       I_BYTE_HALF_SELECT,
   input  wire logic [1:0]                 I_HOST_REGISTER_SELECT,
   input  wire logic [hpi_pkg::ADDR_W-1:0] I_HOST_ADDRESS_BUS,
   input  wire logic [hpi_pkg::DATA_W-1:0] I_HOST_DATA_BUS,
   output logic      [hpi_pkg::DATA_W-1:0] O_HOST_DATA_BUS,
   output logic                            O_HOST_DATA_BUS_OE,
   output logic                            O_HOST_ACCESS_READY,
   output logic                            O_HOST_INT_N,
   // processor side
   input  wire logic                       I_CPU_SET_HOST_INT,
   input  wire logic                       I_CPU_CLR_DEV_INT,
   output logic                            O_DEV_INT,
   input  wire logic                       I_CPU_REQ,
   input  wire logic [hpi_pkg::ADDR_W-1:0] I_CPU_ADDR,
   output logic                            O_CPU_WAIT,
   // dma bus
   output logic                            O_DMA_REQ,
   output logic                            O_DMA_WE,
   output logic      [hpi_pkg::ADDR_W-1:0] O_DMA_ADDR,
   output logic      [hpi_pkg::DATA_W-1:0] O_DMA_WDATA,
   input  wire logic                       I_DMA_ACK,
   input  wire logic [hpi_pkg::DATA_W-1:0] I_DMA_RDATA
);
   localparam int AW = hpi_pkg::ADDR_W;
   localparam int DW = hpi_pkg::DATA_W;
   localparam int BW = hpi_pkg::BYTE_W;
   localparam int FW = AW + DW;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [hpi_pkg::SYNC_W-1:0] meta_q, sync_q;
   logic                        wide, cs_n, dsa_n, dsb_n, rnw, half;
   logic [1:0]                  sel;
   logic [AW-1:0]               ha;
   logic [DW-1:0]               hd;

   // two flops on every host pin; only sync_q is read
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         meta_q <= hpi_pkg::SYNC_RST;
         sync_q <= hpi_pkg::SYNC_RST;
      end else begin
         meta_q <= {I_HOST_WIDTH_SELECT, I_HOST_CHIP_SELECT_N,
                    I_HOST_DATA_STROBE_A_N, I_HOST_DATA_STROBE_B_N,
                    I_HOST_READ_NOT_WRITE, I_BYTE_HALF_SELECT,
                    I_HOST_REGISTER_SELECT, I_HOST_ADDRESS_BUS,
                    I_HOST_DATA_BUS};
         sync_q <= meta_q;
      end
   end

   // unpack synchronised pins
   assign {wide, cs_n, dsa_n, dsb_n, rnw, half, sel, ha, hd} = sync_q;

   // ------------------------------------------------------------
   // write buffer toward the dma bus
   // ------------------------------------------------------------
   logic          fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [FW-1:0] fifo_out;
   logic          wr_pend_q, wr_pend_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [DW-1:0] wdata_q, wdata_d;

   hpi_fifo #(
      .WIDTH (FW),
      .DEPTH (hpi_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .i_clk   (I_CLK),
      .i_rst_n (I_RESET_N),
      .i_valid (wr_pend_q),
      .o_ready (fifo_in_ready),
      .i_data  ({addr_q, wdata_q}),
      .o_valid (fifo_out_valid),
      .i_ready (fifo_pop),
      .o_data  (fifo_out)
   );

   // ------------------------------------------------------------
   // host access decode and sequencer
   // ------------------------------------------------------------
   hpi_pkg::hpi_state_t st_q, st_d;
   logic          act, act_q, start;
   logic          rd_pend_q, rd_pend_d, inc_q, inc_d, ready_q, ready_d;
   logic [BW-1:0] hibyte_q, hibyte_d;
   logic [DW-1:0] rdata_q, rdata_d, hout_q, hout_d, ctrl_word;
   logic          oe_q, oe_d, dev_int_q, dev_int_d, hint_n_q, hint_n_d;
   logic          dev_set, host_clr;
   logic          dreq_q, dreq_d, dwe_q, dwe_d, wait_q, wait_d;
   logic [AW-1:0] daddr_q, daddr_d;
   logic [DW-1:0] dwd_q, dwd_d;

   // either data strobe under chip select opens an access
   assign act   = !cs_n && (!dsa_n || !dsb_n);
   assign start = act && !act_q;

   // control word as the host reads it in each byte half
   always_comb begin
      ctrl_word = hpi_pkg::DATA_RST;
      ctrl_word[hpi_pkg::CTRL_DEV_INT_BIT]     = dev_int_q;
      ctrl_word[hpi_pkg::CTRL_HOST_INT_BIT]    = !hint_n_q;
      ctrl_word[hpi_pkg::CTRL_DEV_INT_BIT+BW]  = dev_int_q;
      ctrl_word[hpi_pkg::CTRL_HOST_INT_BIT+BW] = !hint_n_q;
   end

   // next state of the port, except interrupt flags, host read data and processor wait
   always_comb begin
      st_d      = st_q;
      rd_pend_d = rd_pend_q;
      wr_pend_d = wr_pend_q;
      inc_d     = inc_q;
      ready_d   = ready_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      hibyte_d  = hibyte_q;
      rdata_d   = rdata_q;
      dreq_d    = dreq_q;
      dwe_d     = dwe_q;
      daddr_d   = daddr_q;
      dwd_d     = dwd_q;
      fifo_pop  = 1'b0;
      dev_set   = 1'b0;
      host_clr  = 1'b0;
      // a new host access
      if (start) begin
         if (wide) begin
            // separate address bus gives the whole map
            addr_d = ha;
            inc_d  = 1'b0;
            if (rnw) begin
               rd_pend_d = 1'b1;
            end else begin
               wdata_d   = hd;
               wr_pend_d = 1'b1;
            end
            ready_d = 1'b0;
         end else begin
            case (sel)
               hpi_pkg::SEL_CTRL: begin
                  if (!rnw && half) begin
                     dev_set  = hd[hpi_pkg::CTRL_DEV_INT_BIT];
                     host_clr = hd[hpi_pkg::CTRL_HOST_INT_BIT];
                  end
               end
               hpi_pkg::SEL_ADDR: begin
                  if (!rnw && !half) begin
                     hibyte_d = hd[BW-1:0];
                  end else if (!rnw) begin
                     addr_d = {2'h0, hibyte_q, hd[BW-1:0]};
                  end
               end
               default: begin
                  if (!rnw && !half) begin
                     hibyte_d = hd[BW-1:0];
                  end else if (!rnw) begin
                     wdata_d   = {hibyte_q, hd[BW-1:0]};
                     wr_pend_d = 1'b1;
                     inc_d     = (sel == hpi_pkg::SEL_DATA_INC);
                     ready_d   = 1'b0;
                  end else if (!half) begin
                     rd_pend_d = 1'b1;
                     ready_d   = 1'b0;
                  end else if (sel == hpi_pkg::SEL_DATA_INC) begin
                     addr_d = addr_q + 18'h00001;
                  end
               end
            endcase
         end
      end
      // a pending write enters the buffer, then steps the address when auto-incrementing
      if (wr_pend_q && fifo_in_ready) begin
         wr_pend_d = 1'b0;
         ready_d   = 1'b1;
         if (inc_q) begin
            addr_d = addr_q + 18'h00001;
         end
      end
      // dma sequencer; no halt input gates it
      case (st_q)
         hpi_pkg::ST_IDLE: begin
            if (fifo_out_valid) begin
               fifo_pop = 1'b1;
               dreq_d   = 1'b1;
               dwe_d    = 1'b1;
               daddr_d  = fifo_out[FW-1:DW];
               dwd_d    = fifo_out[DW-1:0];
               st_d     = hpi_pkg::ST_WR_DMA;
            end else if (rd_pend_q) begin
               // reads wait for buffered writes to drain
               dreq_d  = 1'b1;
               dwe_d   = 1'b0;
               daddr_d = addr_q;
               st_d    = hpi_pkg::ST_RD_DMA;
            end
         end
         hpi_pkg::ST_WR_DMA: begin
            if (I_DMA_ACK) begin
               dreq_d = 1'b0;
               st_d   = hpi_pkg::ST_IDLE;
            end
         end
         hpi_pkg::ST_RD_DMA: begin
            if (I_DMA_ACK) begin
               dreq_d    = 1'b0;
               rdata_d   = I_DMA_RDATA;
               rd_pend_d = 1'b0;
               ready_d   = 1'b1;
               st_d      = hpi_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d = hpi_pkg::ST_IDLE;
         end
      endcase
   end

   // interrupt flags: a set wins over a clear in the same cycle
   always_comb begin
      dev_int_d = dev_set || (dev_int_q && !I_CPU_CLR_DEV_INT);
      hint_n_d  = !(I_CPU_SET_HOST_INT || (!hint_n_q && !host_clr));
   end

   // host read data and processor collision wait
   always_comb begin
      oe_d   = act && rnw;
      hout_d = rdata_q;
      if (!wide) begin
         // byte mode: only the low lane carries data
         hout_d = hpi_pkg::DATA_RST;
         case (sel)
            hpi_pkg::SEL_CTRL: begin
               hout_d[BW-1:0] = half ? ctrl_word[BW-1:0] : ctrl_word[DW-1:BW];
            end
            hpi_pkg::SEL_ADDR: begin
               hout_d[BW-1:0] = half ? addr_q[BW-1:0] : addr_q[DW-1:BW];
            end
            default: begin
               hout_d[BW-1:0] = half ? rdata_q[BW-1:0] : rdata_q[DW-1:BW];
            end
         endcase
      end
      wait_d = I_CPU_REQ && dreq_q && (I_CPU_ADDR == daddr_q);
   end

   // register everything
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_q      <= hpi_pkg::ST_IDLE;
         act_q     <= 1'b0;
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         inc_q     <= 1'b0;
         ready_q   <= 1'b1;
         addr_q    <= hpi_pkg::ADDR_RST;
         wdata_q   <= hpi_pkg::DATA_RST;
         hibyte_q  <= hpi_pkg::BYTE_RST;
         rdata_q   <= hpi_pkg::DATA_RST;
         hout_q    <= hpi_pkg::DATA_RST;
         oe_q      <= 1'b0;
         dev_int_q <= 1'b0;
         hint_n_q  <= 1'b1;
         dreq_q    <= 1'b0;
         dwe_q     <= 1'b0;
         daddr_q   <= hpi_pkg::ADDR_RST;
         dwd_q     <= hpi_pkg::DATA_RST;
         wait_q    <= 1'b0;
      end else begin
         st_q      <= st_d;
         act_q     <= act;
         rd_pend_q <= rd_pend_d;
         wr_pend_q <= wr_pend_d;
         inc_q     <= inc_d;
         ready_q   <= ready_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         hibyte_q  <= hibyte_d;
         rdata_q   <= rdata_d;
         hout_q    <= hout_d;
         oe_q      <= oe_d;
         dev_int_q <= dev_int_d;
         hint_n_q  <= hint_n_d;
         dreq_q    <= dreq_d;
         dwe_q     <= dwe_d;
         daddr_q   <= daddr_d;
         dwd_q     <= dwd_d;
         wait_q    <= wait_d;
      end
   end

   // outputs straight from flops
   assign O_HOST_DATA_BUS     = hout_q;
   assign O_HOST_DATA_BUS_OE  = oe_q;
   assign O_HOST_ACCESS_READY = ready_q;
   assign O_HOST_INT_N        = hint_n_q;
   assign O_DEV_INT           = dev_int_q;
   assign O_CPU_WAIT          = wait_q;
   assign O_DMA_REQ           = dreq_q;
   assign O_DMA_WE            = dwe_q;
   assign O_DMA_ADDR          = daddr_q;
   assign O_DMA_WDATA         = dwd_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_ready_stall: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      rd_pend_q |-> !O_HOST_ACCESS_READY)
      else $error("ready high while a read is pending");

   a_word_wr_dma: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (start && wide && !rnw) |-> ##[1:40] (O_DMA_REQ && O_DMA_WE))
      else $error("word write launched no dma write");

   a_word_rd_pend: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (start && wide && rnw) |=> rd_pend_q)
      else $error("word read left no read pending");

   a_word_rd_dma: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (rd_pend_q && st_q == hpi_pkg::ST_IDLE && !fifo_out_valid)
      |=> (O_DMA_REQ && !O_DMA_WE && O_DMA_ADDR == $past(addr_q)))
      else $error("pending read launched no dma read");

   a_word_addr: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (start && wide) |=> (addr_q == $past(ha)))
      else $error("address bus not taken on word access");

   a_ctrl_word: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (wide && !I_CPU_CLR_DEV_INT) |=> $stable(dev_int_q))
      else $error("control changed by host in word mode");

   a_dev_int: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      dev_set |=> O_DEV_INT)
      else $error("processor interrupt not raised");

   a_host_int: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      I_CPU_SET_HOST_INT |=> !O_HOST_INT_N)
      else $error("host interrupt not raised");

   a_cpu_wait: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (I_CPU_REQ && O_DMA_REQ && I_CPU_ADDR == O_DMA_ADDR) |=> O_CPU_WAIT)
      else $error("processor not held on collision");

   a_byte_lane: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (O_HOST_DATA_BUS_OE && $past(!wide) && !wide) |-> (O_HOST_DATA_BUS[15:8] == 8'h00))
      else $error("upper lane driven in byte mode");

   a_auto_inc: assert property (
      @(posedge I_CLK) disable iff (!I_RESET_N)
      (wr_pend_q && fifo_in_ready && inc_q && !start) |=> (addr_q == $past(addr_q) + 18'h00001))
      else $error("address did not step after write");
endmodule : hpi_port
`default_nettype wire

// ### testbench/hpi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// on-chip memory behind the dma bus, with a settable delay
// ---------------------------------------------------------------
module hpi_mem_model (
   // clock
   input  wire logic        i_clk,
   // dma request side
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [17:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic [7:0]  i_delay,
   // answer side
   output logic             o_ack,
   output logic [15:0]      o_rdata
);
   logic [15:0] mem [logic [17:0]];
   int          wait_cnt = 0;

   initial o_ack = 1'b0;
   initial o_rdata = 16'h0000;

   // answer each request once after the delay; read data churns outside the ack
   always @(posedge i_clk) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (wait_cnt >= int'(i_delay)) begin
            o_ack    <= 1'b1;
            wait_cnt <= 0;
            if (i_we) begin
               mem[i_addr] = i_wdata;
            end else begin
               o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
            end
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule : hpi_mem_model
`default_nettype wire

// ### testbench/host_port_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_interface_tb_top;
   // ---------------------------------------------------------------
   // stimulus and observed pins
   // ---------------------------------------------------------------
   logic        clk       = 1'b0;
   logic        rst_n     = 1'b0;
   logic        width_sel = 1'b1;
   logic        cs_n      = 1'b1;
   logic        ds_a_n    = 1'b1;
   logic        ds_b_n    = 1'b1;
   logic        rnw       = 1'b1;
   logic        half      = 1'b0;
   logic [1:0]  reg_sel   = 2'h0;
   logic [17:0] haddr     = 18'h00000;
   logic [15:0] hdin      = 16'h0000;
   logic        set_hint  = 1'b0;
   logic        clr_dint  = 1'b0;
   logic        cpu_req   = 1'b0;
   logic [17:0] cpu_addr  = 18'h00000;
   logic [7:0]  mem_delay = 8'h00;
   logic [15:0] hdout;
   logic        hoe;
   logic        host_access_ready;
   logic        hint_n;
   logic        dint;
   logic        cpu_wait;
   logic        dreq;
   logic        dwe;
   logic [17:0] daddr;
   logic [15:0] dwdata;
   logic        dack;
   logic [15:0] drdata;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          seed       = 66;
   int          last_wait  = 0;
   logic [15:0] ref_mem [logic [17:0]];

   always #5 clk = ~clk;

   hpi_port u_dut (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_HOST_WIDTH_SELECT(width_sel),
      .I_HOST_CHIP_SELECT_N(cs_n), .I_HOST_DATA_STROBE_A_N(ds_a_n),
      .I_HOST_DATA_STROBE_B_N(ds_b_n), .I_HOST_READ_NOT_WRITE(rnw),
      .I_BYTE_HALF_SELECT(half), .I_HOST_REGISTER_SELECT(reg_sel),
      .I_HOST_ADDRESS_BUS(haddr), .I_HOST_DATA_BUS(hdin), .O_HOST_DATA_BUS(hdout),
      .O_HOST_DATA_BUS_OE(hoe), .O_HOST_ACCESS_READY(host_access_ready), .O_HOST_INT_N(hint_n),
      .I_CPU_SET_HOST_INT(set_hint), .I_CPU_CLR_DEV_INT(clr_dint), .O_DEV_INT(dint),
      .I_CPU_REQ(cpu_req), .I_CPU_ADDR(cpu_addr), .O_CPU_WAIT(cpu_wait),
      .O_DMA_REQ(dreq), .O_DMA_WE(dwe), .O_DMA_ADDR(daddr), .O_DMA_WDATA(dwdata),
      .I_DMA_ACK(dack), .I_DMA_RDATA(drdata));

   hpi_mem_model u_mem (
      .i_clk(clk), .i_req(dreq), .i_we(dwe), .i_addr(daddr), .i_wdata(dwdata),
      .i_delay(mem_delay), .o_ack(dack), .o_rdata(drdata));

   // ---------------------------------------------------------------
   // compare, verdict and host cycles
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // one host access: strobe, hold through the stall, take data, release
   task automatic host_access(input logic r, input logic [1:0] sel, input logic h,
                              input logic [17:0] a, input logic [15:0] d,
                              output logic [15:0] q);
      logic sb;
      sb = 1'($random(seed));
      @(negedge clk);
      rnw = r; reg_sel = sel; half = h; haddr = a; hdin = d;
      cs_n = 1'b0; ds_a_n = sb; ds_b_n = ~sb;
      repeat (5) @(negedge clk);
      last_wait = 0;
      while (host_access_ready !== 1'b1 && last_wait < 1000) begin
         @(negedge clk);
         last_wait++;
      end
      if (last_wait == 1000) begin
         fail_count++;
         test_done();
      end
      repeat (2) @(negedge clk);
      q = hdout;
      check("data drive", {17'h0, hoe}, {17'h0, r});
      cs_n = 1'b1; ds_a_n = 1'b1; ds_b_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask : host_access

   task automatic bw(input logic [1:0] sel, input logic [7:0] hi, input logic [7:0] lo);
      logic [15:0] q;
      host_access(1'b0, sel, 1'b0, 18'h00000, {8'h00, hi}, q);
      host_access(1'b0, sel, 1'b1, 18'h00000, {8'h00, lo}, q);
   endtask : bw

   task automatic br(input logic [1:0] sel, output logic [15:0] w);
      logic [15:0] q0;
      logic [15:0] q1;
      host_access(1'b1, sel, 1'b0, 18'h00000, 16'h0000, q0);
      host_access(1'b1, sel, 1'b1, 18'h00000, 16'h0000, q1);
      w = {q0[7:0], q1[7:0]};
   endtask : br

   task automatic w_wr(input logic [17:0] a, input logic [15:0] d);
      logic [15:0] q;
      host_access(1'b0, hpi_pkg::SEL_DATA, 1'b0, a, d, q);
      ref_mem[a] = d;
   endtask : w_wr

   task automatic w_rd(input logic [17:0] a);
      logic [15:0] q;
      host_access(1'b1, hpi_pkg::SEL_DATA, 1'b0, a, 16'h0000, q);
      check("word read", {2'h0, q}, {2'h0, ref_mem[a]});
   endtask : w_rd

   // main sequence: word mode traffic, then byte mode
   initial begin
      logic [17:0] a;
      logic [15:0] w;
      logic [17:0] al[$];
      int          n;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      check("reset ready", {17'h0, host_access_ready}, 18'h00001);
      check("reset dma", {16'h0, dreq, hoe}, 18'h00000);
      al = '{18'h00000, 18'h3ffff};
      for (int i = 0; i < 22; i++) al.push_back(18'($random(seed)));
      foreach (al[i]) begin
         mem_delay = 8'($unsigned($random(seed)) % 7);
         w_wr(al[i], 16'($random(seed)));
      end
      mem_delay = 8'h3c;
      for (int i = 0; i < 6; i++) w_wr(al[i] ^ 18'h00100, 16'($random(seed)));
      foreach (al[i]) w_rd(al[i]);
      mem_delay = 8'h1e;
      w_rd(al[2]);
      check("read stall", {17'h0, last_wait > 20}, 18'h00001);
      a = 18'h2a5a5;
      mem_delay = 8'h28;
      fork
         w_wr(a, 16'hc3c3);
         begin
            n = 0;
            while (dreq !== 1'b1 && n < 100) begin
               @(negedge clk);
               n++;
            end
            if (n == 100) begin
               fail_count++;
               test_done();
            end
            cpu_req = 1'b1; cpu_addr = a;
            @(negedge clk);
            check("cpu wait", {17'h0, cpu_wait}, 18'h00001);
            cpu_addr = a ^ 18'h00001;
            @(negedge clk);
            check("cpu no wait", {17'h0, cpu_wait}, 18'h00000);
            cpu_req = 1'b0;
         end
      join
      mem_delay = 8'h02;
      set_hint = 1'b1;
      @(negedge clk);
      set_hint = 1'b0;
      @(negedge clk);
      check("host int", {17'h0, hint_n}, 18'h00000);
      rst_n = 1'b0;
      width_sel = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      bw(hpi_pkg::SEL_ADDR, 8'h12, 8'h34);
      br(hpi_pkg::SEL_ADDR, w);
      check("addr read", {2'h0, w}, 18'h01234);
      bw(hpi_pkg::SEL_DATA_INC, 8'hbe, 8'hef);
      bw(hpi_pkg::SEL_DATA_INC, 8'h5a, 8'h0f);
      bw(hpi_pkg::SEL_ADDR, 8'h12, 8'h34);
      br(hpi_pkg::SEL_DATA_INC, w);
      check("inc read 0", {2'h0, w}, 18'h0beef);
      br(hpi_pkg::SEL_DATA_INC, w);
      check("inc read 1", {2'h0, w}, 18'h05a0f);
      bw(hpi_pkg::SEL_ADDR, 8'h00, 8'h00);
      for (int i = 0; i < 2; i++) begin
         br(hpi_pkg::SEL_DATA, w);
         check("fixed read", {2'h0, w}, {2'h0, ref_mem[18'h00000]});
      end
      bw(hpi_pkg::SEL_CTRL, 8'h00, 8'h02);
      check("dev int", {17'h0, dint}, 18'h00001);
      @(negedge clk);
      clr_dint = 1'b1;
      @(negedge clk);
      clr_dint = 1'b0;
      @(negedge clk);
      check("dev int clear", {17'h0, dint}, 18'h00000);
      set_hint = 1'b1;
      @(negedge clk);
      set_hint = 1'b0;
      br(hpi_pkg::SEL_CTRL, w);
      check("ctrl read", {2'h0, w}, 18'h00404);
      bw(hpi_pkg::SEL_CTRL, 8'h00, 8'h04);
      check("host int clear", {17'h0, hint_n}, 18'h00001);
      test_done();
   end
endmodule : host_port_interface_tb_top
`default_nettype wire
